// file: shared/sew_pkg.sv
// Shared constants and helper functions for the two-wire serial memory slave and its master
package sew_pkg;
   // Device address word layout
   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam int DEV_TYPE_MSB = 7;
   localparam int DEV_TYPE_LSB = 4;
   localparam int DEV_SEL_MSB = 3;
   localparam int DEV_SEL_LSB = 1;
   localparam int DEV_RW_BIT = 0;
   localparam int WORD_BITS = 8;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_SLOT = 4'h9;
   // Capacity codes 0..4 stand for 1K, 2K, 4K, 8K and 16K arrays
   localparam int CAP_1K = 0;
   localparam int CAP_2K = 1;
   localparam int CAP_4K = 2;
   localparam int CAP_8K = 3;
   localparam int CAP_16K = 4;
   localparam int ADDR_MAX = 11;
   localparam int SMALL_PAGE_BITS = 3;
   localparam int LARGE_PAGE_BITS = 4;
   // Self-timed programming time in microseconds at a 100 MHz clock
   localparam int PROG_TIME_US = 10000;
   localparam int CLK_MHZ = 100;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int SCL_HALF_CYCLES = 250;
   localparam logic [10:0] ADDR_RESET = 11'h000;

   // Number of page-select bits in the device address for a capacity
   function automatic int page_sel_bits(input int cap);
      page_sel_bits = (cap <= CAP_2K) ? 0 : cap - CAP_2K;
   endfunction

   // Page size expressed as address bits that wrap inside one page
   function automatic int page_bits(input int cap);
      page_bits = (cap <= CAP_2K) ? SMALL_PAGE_BITS : LARGE_PAGE_BITS;
   endfunction
endpackage

// file: shared/sew_bus_if.sv
// Two-wire bus carrier joining the memory slave and the master
`timescale 1ns/1ns
interface sew_bus_if;
   logic scl;
   logic sda_slave_oe;
   logic sda_master_oe;
   logic sda;
   // Open-drain wire with external pull-up
   assign sda = !(sda_slave_oe || sda_master_oe);

   modport slave (
      input scl,
      input sda,
      output sda_slave_oe
   );
   modport master (
      output scl,
      input sda,
      output sda_master_oe
   );
endinterface

// file: src/sew_fifo.sv
// Small valid/ready FIFO used in the master's data path
`timescale 1ns/1ns
module sew_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("Depth must be a power of two of at least two");
      end
   end

   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } sew_fifo_st_t;

   sew_fifo_st_t s_q, s_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push, pop;

   assign in_ready = (s_q.wr - s_q.rd) != (AW+1)'(DEPTH);
   assign out_valid = s_q.wr != s_q.rd;
   assign out_data = mem_q[s_q.rd[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wr = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[s_q.wr[AW-1:0]] <= in_data;
      end
   end
endmodule

// file: src/sew_slave.sv
// Memory-side two-wire slave: framing, addressing, page write and programming cycle
`timescale 1ns/1ns
module sew_slave #(
   parameter int CAPACITY = sew_pkg::CAP_2K,
   parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Two-wire bus
   sew_bus_if.slave bus,
   // Hard-wired select pins
   input wire logic chip_select_pin_low,
   input wire logic chip_select_pin_mid,
   input wire logic chip_select_pin_high,
   // Write port toward the array
   output logic wr_en,
   output logic [sew_pkg::ADDR_MAX-1:0] wr_addr,
   output logic [7:0] wr_data,
   // Status
   output logic standby,
   output logic programming
);
   localparam int PSB = sew_pkg::page_sel_bits(CAPACITY);
   localparam int PB = sew_pkg::page_bits(CAPACITY);
   localparam int AB = 7 + CAPACITY;
   localparam int PW = $clog2(PROG_CYCLES + 1);
   localparam int PDEPTH = 1 << PB;
   initial begin
      if (CAPACITY < sew_pkg::CAP_1K || CAPACITY > sew_pkg::CAP_16K || PROG_CYCLES < 1) begin
         $error("Unsupported capacity or programming time");
      end
   end

   typedef enum logic [2:0] {
      SEW_IDLE, SEW_DEV, SEW_WADDR, SEW_DATA, SEW_READ, SEW_PROG
   } sew_state_t;

   typedef struct packed {
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_p;
      logic sda_p;
      sew_state_t st;
      logic [3:0] bitc;
      logic [7:0] shf;
      logic ack;
      logic acked;
      logic [AB-1:0] addr;
      logic [PB:0] nbytes;
      logic [PW-1:0] pcnt;
      logic pend;
      logic [PB:0] flush;
      logic wr_en;
      logic [sew_pkg::ADDR_MAX-1:0] wr_addr;
      logic [7:0] wr_data;
      logic standby;
   } sew_slave_st_t;

   sew_slave_st_t s_q, s_d;
   logic [7:0] page_mem_q [PDEPTH];
   logic [PB-1:0] page_idx_q [PDEPTH];
   logic scl_rise, scl_fall, start_ev, stop_ev, sel_ok;
   logic [2:0] pins;
   logic [7:0] word;
   logic [PB-1:0] fl_idx;

   assign pins = {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
   assign scl_rise = s_q.scl_s[1] && !s_q.scl_p;
   assign scl_fall = !s_q.scl_s[1] && s_q.scl_p;
   // Data change while the clock stays high is framing, never data
   assign start_ev = s_q.scl_s[1] && s_q.scl_p && s_q.sda_p && !s_q.sda_s[1];
   assign stop_ev = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_p && s_q.sda_s[1];
   assign word = {s_q.shf[6:0], s_q.sda_s[1]};
   assign fl_idx = PB'(s_q.flush - 1'b1);
   // Only select bits above the page-select bits are compared with pins
   assign sel_ok = (s_q.shf[sew_pkg::DEV_TYPE_MSB:sew_pkg::DEV_TYPE_LSB] == sew_pkg::DEV_TYPE_CODE)
      && ((s_q.shf[sew_pkg::DEV_SEL_MSB:sew_pkg::DEV_SEL_LSB] >> PSB) == (pins >> PSB));

   assign bus.sda_slave_oe = s_q.ack;
   assign wr_en = s_q.wr_en;
   assign wr_addr = s_q.wr_addr;
   assign wr_data = s_q.wr_data;
   assign standby = s_q.standby;
   assign programming = s_q.st == SEW_PROG;

   always_comb begin
      s_d = s_q;
      s_d.scl_s = {s_q.scl_s[0], bus.scl};
      s_d.sda_s = {s_q.sda_s[0], bus.sda};
      s_d.scl_p = s_q.scl_s[1];
      s_d.sda_p = s_q.sda_s[1];
      s_d.wr_en = 1'b0;
      if (s_q.st == SEW_PROG) begin
         // Buffered page is written out one byte per cycle while the timer runs
         if (s_q.flush != '0) begin
            s_d.flush = s_q.flush - 1'b1;
            s_d.wr_en = 1'b1;
            s_d.wr_addr = sew_pkg::ADDR_MAX'({s_q.addr[AB-1:PB], page_idx_q[fl_idx]});
            s_d.wr_data = page_mem_q[page_idx_q[fl_idx]];
         end
         if (s_q.pcnt != '0) begin
            s_d.pcnt = s_q.pcnt - 1'b1;
         end else if (s_q.flush == '0) begin
            s_d.st = SEW_IDLE;
            s_d.standby = 1'b1;
         end
      end else if (start_ev) begin
         s_d.st = SEW_DEV;
         // The clock fall that closes the start is not a data bit
         s_d.bitc = sew_pkg::ACK_SLOT;
         s_d.pend = 1'b0;
         s_d.ack = 1'b0;
         s_d.standby = 1'b0;
      end else if (stop_ev) begin
         s_d.ack = 1'b0;
         if (s_q.pend) begin
            // Write sequence ended: enter the self-timed cycle
            s_d.st = SEW_PROG;
            s_d.pcnt = PW'(PROG_CYCLES - 1);
            s_d.flush = s_q.nbytes;
            s_d.pend = 1'b0;
         end else begin
            s_d.st = SEW_IDLE;
            s_d.standby = 1'b1;
         end
      end else if (s_q.st != SEW_IDLE) begin
         if (scl_rise && s_q.bitc < sew_pkg::ACK_SLOT) begin
            s_d.shf = word;
         end
         if (scl_rise && s_q.bitc == sew_pkg::ACK_SLOT) begin
            s_d.acked = 1'b1;
         end
         if (scl_fall) begin
            s_d.bitc = s_q.bitc + 1'b1;
            if (s_q.bitc == sew_pkg::LAST_SLOT - 4'h2) begin
               // Eighth bit done: decide acknowledge for the ninth clock
               s_d.ack = 1'b1;
               case (s_q.st)
                  SEW_DEV: begin
                     if (!sel_ok) begin
                        s_d.ack = 1'b0;
                        s_d.st = SEW_IDLE;
                        s_d.standby = 1'b1;
                     end else if (s_q.shf[sew_pkg::DEV_RW_BIT]) begin
                        s_d.st = SEW_READ;
                     end else begin
                        s_d.st = SEW_WADDR;
                     end
                     if (sel_ok && PSB > 0) begin
                        s_d.addr = AB'(s_q.addr & ({AB{1'b1}} >> PSB))
                           | AB'(AB'(s_q.shf[sew_pkg::DEV_SEL_LSB +: 3]) << (AB - PSB));
                     end
                  end
                  SEW_WADDR: begin
                     s_d.addr = AB'(s_q.addr & ~AB'(8'hFF)) | AB'(s_q.shf);
                     s_d.st = SEW_DATA;
                     s_d.nbytes = '0;
                  end
                  SEW_DATA: begin
                     // Wrap inside the page; excess bytes replace earlier ones
                     s_d.addr[PB-1:0] = s_q.addr[PB-1:0] + 1'b1;
                     s_d.pend = 1'b1;
                     if (s_q.nbytes != (PB+1)'(PDEPTH)) begin
                        s_d.nbytes = s_q.nbytes + 1'b1;
                     end
                  end
                  SEW_READ: begin
                     s_d.ack = 1'b1;
                  end
                  default: begin
                     s_d.st = SEW_IDLE;
                  end
               endcase
            end else if (s_q.bitc == sew_pkg::ACK_SLOT) begin
               s_d.ack = 1'b0;
               s_d.bitc = '0;
               // Reads are outside this front end; release and wait for a start
               if (s_q.st == SEW_READ) begin
                  s_d.st = SEW_IDLE;
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.scl_s <= 2'h3;
         s_q.sda_s <= 2'h3;
         s_q.scl_p <= 1'b1;
         s_q.sda_p <= 1'b1;
         s_q.st <= SEW_IDLE;
         s_q.addr <= AB'(sew_pkg::ADDR_RESET);
         s_q.standby <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Page buffer: latched at the data byte's acknowledge decision
   always_ff @(posedge ref_clk) begin
      if (s_q.st == SEW_DATA && scl_fall && !start_ev && !stop_ev
            && s_q.bitc == sew_pkg::LAST_SLOT - 4'h2) begin
         page_mem_q[s_q.addr[PB-1:0]] <= s_q.shf;
         // Arrival order of distinct offsets; a rolled-over byte only replaces data
         if (s_q.nbytes != (PB+1)'(PDEPTH)) begin
            page_idx_q[s_q.nbytes[PB-1:0]] <= s_q.addr[PB-1:0];
         end
      end
   end
endmodule

// file: src/sew_master.sv
// Bus-master end: sends write sequences, polls for acknowledge, recovers the bus
`timescale 1ns/1ns
module sew_master #(
   parameter int HALF = sew_pkg::SCL_HALF_CYCLES,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Two-wire bus
   sew_bus_if.master bus,
   // Command: device select word and first word address
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_dev,
   input wire logic [7:0] cmd_addr,
   input wire logic recover,
   // Data bytes, last marks final byte of the page
   input wire logic dat_valid,
   output logic dat_ready,
   input wire logic [8:0] dat_in,
   // Status
   output logic busy,
   output logic nack_seen
);
   localparam int HW = $clog2(HALF + 1);
   initial begin
      if (HALF < 2) begin
         $error("Half period too short");
      end
   end

   typedef enum logic [2:0] {
      SEM_IDLE, SEM_START, SEM_BIT, SEM_STOP, SEM_RECOV
   } sew_mstate_t;

   typedef struct packed {
      logic [1:0] sda_s;
      sew_mstate_t st;
      logic [HW-1:0] tick;
      logic ph;
      logic scl;
      logic oe;
      logic [3:0] bitc;
      logic [8:0] shf;
      logic [1:0] wstep;
      logic last;
      logic [3:0] rcnt;
      logic cmd_ready;
      logic busy;
      logic nack;
   } sew_master_st_t;

   sew_master_st_t s_q, s_d;
   logic f_valid, f_pop;
   logic [8:0] f_data;
   logic en;

   sew_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(dat_valid),
      .in_ready(dat_ready),
      .in_data(dat_in),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   assign en = s_q.tick == '0;
   // Pop exactly when the acknowledge branch loads the next byte
   assign f_pop = en && s_q.st == SEM_BIT && s_q.ph && s_q.scl && s_q.bitc == 4'h8 && !s_q.sda_s[1]
      && s_q.wstep != 2'h0 && !s_q.last && f_valid;
   assign bus.scl = s_q.scl;
   assign bus.sda_master_oe = s_q.oe;
   assign cmd_ready = s_q.cmd_ready;
   assign busy = s_q.busy;
   assign nack_seen = s_q.nack;

   always_comb begin
      s_d = s_q;
      s_d.sda_s = {s_q.sda_s[0], bus.sda};
      s_d.tick = en ? HW'(HALF - 1) : s_q.tick - 1'b1;
      s_d.cmd_ready = 1'b0;
      if (en) begin
         case (s_q.st)
            SEM_IDLE: begin
               s_d.scl = 1'b1;
               s_d.oe = 1'b0;
               s_d.busy = 1'b0;
               if (recover) begin
                  s_d.st = SEM_RECOV;
                  s_d.rcnt = '0;
                  s_d.busy = 1'b1;
               end else if (cmd_valid) begin
                  s_d.st = SEM_START;
                  s_d.busy = 1'b1;
                  s_d.wstep = '0;
                  s_d.nack = 1'b0;
                  s_d.last = 1'b0;
                  s_d.shf = {cmd_dev, 1'b1};
               end
            end
            SEM_START: begin
               s_d.oe = 1'b1;
               s_d.st = SEM_BIT;
               s_d.bitc = '0;
               s_d.ph = 1'b0;
            end
            SEM_BIT: begin
               s_d.ph = !s_q.ph;
               if (!s_q.ph) begin
                  // Low phase: change data only while the clock is low
                  s_d.scl = 1'b0;
                  s_d.oe = s_q.bitc == 4'h8 ? 1'b0 : !s_q.shf[8];
               end else if (!s_q.scl) begin
                  s_d.scl = 1'b1;
                  s_d.ph = 1'b1;
               end else begin
                  s_d.ph = 1'b0;
                  s_d.bitc = s_q.bitc + 1'b1;
                  s_d.shf = {s_q.shf[7:0], 1'b1};
                  if (s_q.bitc == 4'h8) begin
                     s_d.bitc = '0;
                     if (s_q.sda_s[1]) begin
                        // No acknowledge: device busy programming, poll again
                        s_d.nack = 1'b1;
                        s_d.st = SEM_STOP;
                        s_d.wstep = 2'h3;
                     end else if (s_q.wstep == 2'h0) begin
                        s_d.wstep = 2'h1;
                        s_d.shf = {cmd_addr, 1'b1};
                        s_d.cmd_ready = 1'b1;
                     end else if (!s_q.last && f_valid) begin
                        s_d.wstep = 2'h2;
                        s_d.shf = {f_data[7:0], 1'b1};
                        s_d.last = f_data[8];
                     end else begin
                        s_d.st = SEM_STOP;
                     end
                  end
               end
            end
            SEM_STOP: begin
               // Pull low under low clock, raise clock, then release for stop
               if (s_q.scl) begin
                  s_d.scl = 1'b0;
                  s_d.oe = 1'b1;
               end else begin
                  s_d.scl = 1'b1;
                  s_d.st = SEM_IDLE;
               end
            end
            SEM_RECOV: begin
               // Up to nine clocks until data reads high with clock high
               s_d.oe = 1'b0;
               s_d.scl = !s_q.scl;
               if (s_q.scl && s_q.sda_s[1]) begin
                  // Clock stays high so the following start is a real start
                  s_d.scl = 1'b1;
                  s_d.wstep = '0;
                  s_d.last = 1'b0;
                  s_d.st = SEM_START;
                  s_d.shf = {cmd_dev, 1'b1};
               end else if (s_q.scl) begin
                  s_d.rcnt = s_q.rcnt + 1'b1;
                  if (s_q.rcnt == 4'h8) begin
                     s_d.st = SEM_IDLE;
                  end
               end
            end
            default: begin
               s_d.st = SEM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.sda_s <= 2'h3;
         s_q.st <= SEM_IDLE;
         s_q.scl <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// file: verification/sew_properties.sv
// Bus-side checks between the memory slave and the master
`timescale 1ns/1ns
module sew_properties #(
   parameter int PROG_CYCLES = 2000
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Bus wires
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_slave_oe,
   // Slave status
   input wire logic wr_en,
   input wire logic standby,
   input wire logic programming
);
   int prog_cnt_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Programming length counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prog_cnt_q <= 0;
      end else begin
         prog_cnt_q <= programming ? prog_cnt_q + 1 : 0;
      end
   end

   // ==========================================
   // Assertions
   AST_RESET_IDLE: assert property ($rose(rst_n) |-> standby && !sda_slave_oe)
      else $error("slave not idle after reset");
   AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_slave_oe) |-> !scl)
      else $error("slave moved data line while clock high");
   AST_ACK_HOLD: assert property ($rose(sda_slave_oe) |-> sda_slave_oe [*8])
      else $error("acknowledge too short");
   // Window assumes a serial half period of about 20 clocks
   AST_ACK_SPAN: assert property ($rose(sda_slave_oe) |-> ##[1:60] (scl && sda_slave_oe))
      else $error("acknowledge not held through ninth clock high");
   AST_ACK_RELEASE: assert property (sda_slave_oe && $fell(scl) |-> ##[1:8] !sda_slave_oe)
      else $error("acknowledge not released after ninth clock");
   AST_PROG_SILENT: assert property (programming |-> !sda_slave_oe)
      else $error("slave answered while programming");
   AST_PROG_LEN: assert property ($fell(programming) |-> prog_cnt_q >= PROG_CYCLES && prog_cnt_q <= PROG_CYCLES + 1)
      else $error("programming length wrong");
   AST_PROG_BOUND: assert property (programming |-> prog_cnt_q <= PROG_CYCLES + 1)
      else $error("programming overruns");
   AST_NO_STANDBY_PROG: assert property (programming |-> !standby)
      else $error("standby while programming");
   AST_STANDBY_AFTER: assert property ($fell(programming) |-> ##[0:2] standby)
      else $error("no standby after programming");
   AST_WR_AFTER_STOP: assert property (wr_en |-> scl && sda)
      else $error("array write before stop");
endmodule

// file: verification/sew_tb_top.sv
// Self-checking bench joining the memory slave and the bus master
`timescale 1ns/1ns
module sew_tb_top;
   localparam int PROG = 2000;
   logic ref_clk = 0;
   logic rst_n = 0;
   logic cmd_valid = 0;
   logic recover = 0;
   logic dat_valid = 0;
   logic [7:0] cmd_dev = 8'h00;
   logic [7:0] cmd_addr = 8'h00;
   logic [8:0] dat_in = 9'h000;
   logic [2:0] pins = 3'h0;
   logic cmd_ready, dat_ready, busy, nack_seen, wr_en, standby, programming;
   logic [10:0] wr_addr;
   logic [7:0] wr_data;
   logic scl_q = 1;
   logic sda_q = 1;
   logic full_seen = 0;
   logic [8:0] sh = 9'h000;
   logic [7:0] dv;
   int error_cnt = 0;
   int cmp_count = 0;
   int bit_cnt = 0;
   int scl_rises = 0;
   logic [8:0] mon_q[$];
   logic [7:0] dut_mem[int];
   int model_mem[int];
   logic [7:0] bytes[$];

   sew_bus_if bus_if();
   always #5 ref_clk = ~ref_clk;

   sew_slave #(.CAPACITY(sew_pkg::CAP_4K), .PROG_CYCLES(PROG)) sew_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .bus(bus_if.slave), .chip_select_pin_low(pins[0]), .chip_select_pin_mid(pins[1]),
      .chip_select_pin_high(pins[2]), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .standby(standby),
      .programming(programming));
   sew_master #(.HALF(20), .DEPTH(4)) sew_master_inst (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus_if.master),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .recover(recover),
      .dat_valid(dat_valid), .dat_ready(dat_ready), .dat_in(dat_in), .busy(busy), .nack_seen(nack_seen));
   sew_properties #(.PROG_CYCLES(PROG)) sew_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n), .scl(bus_if.scl),
      .sda(bus_if.sda), .sda_slave_oe(bus_if.sda_slave_oe), .wr_en(wr_en), .standby(standby),
      .programming(programming));

   // ==========================================
   // Wire monitor: words as seen on the bus, array writes
   always @(posedge ref_clk) begin
      if (wr_en) begin
         dut_mem[wr_addr] = wr_data;
      end
      if (bus_if.scl && scl_q && sda_q && !bus_if.sda) begin
         bit_cnt = 0;
      end else if (bus_if.scl && !scl_q) begin
         scl_rises++;
         sh = {sh[7:0], bus_if.sda};
         bit_cnt++;
         if (bit_cnt == 9) begin
            mon_q.push_back(sh);
            bit_cnt = 0;
         end
      end
      if (dat_valid && !dat_ready) begin
         full_seen = 1;
      end
      scl_q = bus_if.scl;
      sda_q = bus_if.sda;
   end

   // ==========================================
   // Checking helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Bounded wait: 0 busy, 1 programming, 2 cmd_ready
   task automatic wait_for(input int which, input logic lvl, input int lim);
      logic s;
      for (int i = 0; i <= lim; i++) begin
         @(posedge ref_clk);
         #1;
         s = (which == 0) ? busy : (which == 1) ? programming : cmd_ready;
         if (s === lvl) begin
            return;
         end
      end
      error_cnt++;
      $display("Error at %0t: wait %0d timed out", $time, which);
      stop_test();
   endtask

   // One command; the model records what the array must hold afterwards
   task automatic run(input logic [7:0] dev, input logic [7:0] addr, input int n, input logic ack);
      int base;
      int k;
      mon_q.delete();
      bytes.delete();
      for (int i = 0; i < n; i++) begin
         bytes.push_back(8'($urandom));
      end
      cmd_dev = dev;
      cmd_addr = addr;
      cmd_valid = 1;
      // A refused device word never brings cmd_ready: then wait for the take
      fork
         wait_for(ack ? 2 : 0, 1'b1, 4000);
         begin
            for (int i = 0; i < n; i++) begin
               dat_in = {i == n - 1, bytes[i]};
               dat_valid = 1;
               k = 0;
               while (!dat_ready && k < 4000) begin
                  @(posedge ref_clk);
                  #1;
                  k++;
               end
               if (k >= 4000) begin
                  error_cnt++;
                  $display("Error at %0t: data push timed out", $time);
                  stop_test();
               end
               @(posedge ref_clk);
               #1;
            end
            dat_valid = 0;
         end
      join
      cmd_valid = 0;
      dat_valid = 0;
      wait_for(0, 1'b0, 20000);
      check(nack_seen, !ack);
      check(mon_q[0], {dev, !ack});
      base = {dev[1], addr};
      if (ack) begin
         check(mon_q[1], {addr, 1'b0});
      end
      for (int i = 0; i < n && ack; i++) begin
         check(mon_q[2 + i], {bytes[i], 1'b0});
         model_mem[(base & 'h1F0) | ((base + i) & 'hF)] = bytes[i];
      end
   endtask

   task automatic settle();
      wait_for(1, 1'b1, 50);
      wait_for(1, 1'b0, PROG + 500);
      check(standby, 1'b1);
      check(16'(dut_mem.size()), 16'(model_mem.size()));
      foreach (model_mem[a]) begin
         check(dut_mem.exists(a) ? dut_mem[a] : 16'hFFFF, 16'(model_mem[a]));
      end
   endtask

   // ==========================================
   // Scenarios
   initial begin
      void'($urandom(27));
      pins = {1'b1, 1'b0, 1'($urandom)};
      dv = {sew_pkg::DEV_TYPE_CODE, 1'b1, 1'b0, 1'($urandom), 1'b0};
      repeat (2) @(posedge ref_clk);
      #1;
      rst_n = 1;
      // Byte write, then a poll that must be refused while programming
      run(dv, 8'($urandom), 1, 1'b1);
      wait_for(1, 1'b1, 400);
      run(dv, 8'h00, 0, 1'b0);
      settle();
      // Full page from mid page, then an overflowing page with a stalled FIFO
      dv[1] = ~dv[1];
      run(dv, {4'($urandom), 4'h9}, 16, 1'b1);
      settle();
      full_seen = 0;
      run(dv, 8'($urandom), 19, 1'b1);
      check(full_seen, 1'b1);
      settle();
      // Wrong select pin, then wrong type code
      run({dv[7:4], 1'b0, dv[2:0]}, 8'h00, 0, 1'b0);
      check(standby, 1'b1);
      run({4'h5, dv[3:0]}, 8'h00, 0, 1'b0);
      // Bus recovery, then a normal page write still lands
      scl_rises = 0;
      recover = 1;
      wait_for(0, 1'b1, 200);
      recover = 0;
      wait_for(0, 1'b0, 4000);
      check(16'(scl_rises <= 10), 16'h0001);
      check({bus_if.scl, bus_if.sda}, 2'b11);
      run(dv, 8'($urandom), 8, 1'b1);
      settle();
      stop_test();
   end
endmodule
